//--- msi_ctrl_end.sv
// Interrupt controller end: AXI4-Lite command registers, frame access, pending capture
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module msi_ctrl_end import msi_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   msi_link_if.ctrl link,
   output logic pending_any,
   output logic config_error
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam logic [NUM_LINES-1:0] NS_LINES = ns_mask();
   logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] ctrl_r, data_r;
   logic busy_r, err_r, req_valid_r;
   logic [NUM_LINES-1:0] pend_r, edge_r, group_r, nsac_r;
   logic [3:0] wstrb_r;

   function automatic logic [31:0] half_of(input logic [63:0] v, input logic hi);
      return hi ? v[63:32] : v[31:0];
   endfunction

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire do_wr = aw_held_r & w_held_r & ~bvalid_r;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire w_ctrl = do_wr && awaddr_r == C_CTRL;
   wire w_data = do_wr && awaddr_r == C_DATA;
   wire w_go = do_wr && awaddr_r == C_GO;
   wire w_stat = do_wr && awaddr_r == C_STATUS;
   wire w_pend = do_wr && awaddr_r[7:3] == C_PEND_LO[7:3];
   wire w_edge = do_wr && awaddr_r[7:3] == C_EDGE_LO[7:3];
   wire w_group = do_wr && awaddr_r[7:3] == C_GROUP_LO[7:3];
   wire w_nsac = do_wr && awaddr_r[7:3] == C_NSAC_LO[7:3];
   wire wr_hi = awaddr_r[2];
   wire wr_map = w_ctrl | w_data | w_go | w_stat | w_pend | w_edge | w_group | w_nsac;
   wire [31:0] bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   wire [31:0] wmask = wdata_r & bmask;
   wire [NUM_LINES-1:0] wmask64 = wr_hi ? {wmask, 32'h00000000} : {32'h00000000, wmask};
   wire [NUM_LINES-1:0] lane64 = wr_hi ? {bmask, 32'h00000000} : {32'h00000000, bmask};
   wire link_done = link.resp_valid & link.resp_ready;
   wire issue = w_go & ~busy_r;

   logic [31:0] rd_word;
   logic rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      if (s_axi_araddr == C_CTRL) begin
         rd_word = ctrl_r;
      end else if (s_axi_araddr == C_DATA) begin
         rd_word = data_r;
      end else if (s_axi_araddr == C_GO) begin
         rd_word = 32'h00000000;
      end else if (s_axi_araddr == C_STATUS) begin
         rd_word = {29'h00000000, config_error, err_r, busy_r};
      end else if (s_axi_araddr[7:3] == C_PEND_LO[7:3]) begin
         rd_word = half_of(pend_r, s_axi_araddr[2]);
      end else if (s_axi_araddr[7:3] == C_EDGE_LO[7:3]) begin
         rd_word = half_of(edge_r, s_axi_araddr[2]);
      end else if (s_axi_araddr[7:3] == C_GROUP_LO[7:3]) begin
         rd_word = half_of(group_r, s_axi_araddr[2]);
      end else if (s_axi_araddr[7:3] == C_NSAC_LO[7:3]) begin
         rd_word = half_of(nsac_r, s_axi_araddr[2]);
      end else begin
         rd_word = 32'h00000000;
         rd_ok = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite channels
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Command registers and frame access
   // ----------------------------------------------------------------
   // Go while busy is dropped so a command in flight cannot be torn
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= 32'h00000000;
         data_r <= 32'h00000000;
         busy_r <= 1'b0;
         err_r <= 1'b0;
         req_valid_r <= 1'b0;
      end else begin
         if (w_ctrl) ctrl_r <= (ctrl_r & ~bmask) | wmask;
         if (w_data) data_r <= (data_r & ~bmask) | wmask;
         if (issue) begin
            busy_r <= 1'b1;
            req_valid_r <= 1'b1;
         end else if (req_valid_r && link.req_ready) begin
            req_valid_r <= 1'b0;
         end
         if (link_done) begin
            busy_r <= 1'b0;
            err_r <= link.resp_err;
            if (!ctrl_r[CTRL_WR_BIT]) data_r <= link.resp_rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt configuration and pending capture
   // ----------------------------------------------------------------
   // Level-configured lines would miss a one-cycle pulse, hence edge only
   wire [NUM_LINES-1:0] sets = link.spi_pulse & edge_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_r <= '0;
         edge_r <= '0;
         group_r <= '0;
         nsac_r <= '0;
      end else begin
         pend_r <= (pend_r & ~(w_pend ? wmask64 : '0)) | sets;
         if (w_edge) edge_r <= (edge_r & ~lane64) | wmask64;
         if (w_group) group_r <= (group_r & ~lane64) | wmask64;
         if (w_nsac) nsac_r <= (nsac_r & ~lane64) | wmask64;
      end
   end

   // Misconfigured security: Non-secure frame line in Group 0 without permission, or secure frame line in Group 1
   wire ns_bad = |(NS_LINES & ~group_r & ~nsac_r);
   wire sec_bad = CTRL_SECURITY_BUILT & (|(link.spi_secure & group_r));

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = ~aw_held_r & ~bvalid_r;
   assign s_axi_wready = ~w_held_r & ~bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign link.req_valid = req_valid_r;
   assign link.req_write = ctrl_r[CTRL_WR_BIT];
   assign link.req_secure = ctrl_r[CTRL_SEC_BIT];
   assign link.req_frame = ctrl_r[CTRL_FRAME_LSB +: FRAME_W];
   assign link.req_addr = ctrl_r[11:0];
   assign link.req_wdata = data_r;
   assign link.req_strb = ctrl_r[CTRL_HALF_BIT] ? STRB_HALF : STRB_WORD;
   assign link.resp_ready = busy_r & ~req_valid_r;
   assign pending_any = |pend_r;
   assign config_error = ns_bad | sec_bad;
endmodule
`default_nettype wire

//--- msi_pkg.sv
// Shared constants, frame layout and helper functions for the message frame block
package msi_pkg;
   // ----------------------------------------------------------------
   // Build configuration
   // ----------------------------------------------------------------
   localparam int NUM_LINES = 64;
   localparam logic [9:0] LINE_BASE_ID = 10'h020;
   localparam int NUM_FRAMES = 3;
   localparam int FRAME_W = 2;
   localparam logic [1:0] SEC_FRAME = 2'h0;
   localparam bit SECURE_FRAME_BUILT = 1'b1;
   localparam bit CTRL_SECURITY_BUILT = 1'b1;
   localparam bit SEC_EFF = SECURE_FRAME_BUILT & CTRL_SECURITY_BUILT;
   localparam logic [9:0] FRAME_BASE [NUM_FRAMES] = '{10'h040, 10'h020, 10'h028};
   localparam logic [9:0] FRAME_COUNT [NUM_FRAMES] = '{10'h008, 10'h008, 10'h008};

   // ----------------------------------------------------------------
   // Frame register offsets and fields
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_TYPE = 12'h008;
   localparam logic [11:0] OFS_TRIGGER = 12'h040;
   localparam logic [11:0] OFS_IDENT = 12'hfcc;
   localparam logic [3:0] STRB_WORD = 4'hf;
   localparam logic [3:0] STRB_HALF = 4'h3;
   // Identity fields, values arbitrary
   localparam logic [11:0] IDENT_PRODUCT = 12'h001;
   localparam logic [3:0] IDENT_ARCH = 4'h0;
   localparam logic [3:0] IDENT_REVISION = 4'h0;
   localparam logic [11:0] IDENT_IMPLEMENTER = 12'h000;

   // ----------------------------------------------------------------
   // Controller-end registers (AXI4-Lite)
   // ----------------------------------------------------------------
   localparam logic [7:0] C_CTRL = 8'h00;
   localparam logic [7:0] C_DATA = 8'h04;
   localparam logic [7:0] C_GO = 8'h08;
   localparam logic [7:0] C_STATUS = 8'h0c;
   localparam logic [7:0] C_PEND_LO = 8'h10;
   localparam logic [7:0] C_PEND_HI = 8'h14;
   localparam logic [7:0] C_EDGE_LO = 8'h18;
   localparam logic [7:0] C_EDGE_HI = 8'h1c;
   localparam logic [7:0] C_GROUP_LO = 8'h20;
   localparam logic [7:0] C_GROUP_HI = 8'h24;
   localparam logic [7:0] C_NSAC_LO = 8'h28;
   localparam logic [7:0] C_NSAC_HI = 8'h2c;
   localparam int CTRL_FRAME_LSB = 12;
   localparam int CTRL_SEC_BIT = 16;
   localparam int CTRL_WR_BIT = 17;
   localparam int CTRL_HALF_BIT = 18;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic id_in_frame(input int f, input logic [9:0] id);
      logic [10:0] lim;
      lim = {1'b0, FRAME_BASE[f]} + {1'b0, FRAME_COUNT[f]};
      return (id >= FRAME_BASE[f]) && ({1'b0, id} < lim);
   endfunction

   function automatic logic [NUM_LINES-1:0] frame_mask(input int f);
      logic [NUM_LINES-1:0] m;
      m = '0;
      for (int i = 0; i < NUM_LINES; i++) begin
         m[i] = id_in_frame(f, LINE_BASE_ID + 10'(i));
      end
      return m;
   endfunction

   function automatic logic [NUM_LINES-1:0] ns_mask();
      logic [NUM_LINES-1:0] m;
      m = '0;
      for (int f = 0; f < NUM_FRAMES; f++) begin
         if (f != int'(SEC_FRAME)) begin
            m = m | frame_mask(f);
         end
      end
      return m;
   endfunction
endpackage

//--- msi_link_if.sv
// Link between the frame unit and the interrupt controller end
`timescale 1ns/10ps
`default_nettype none
interface msi_link_if import msi_pkg::*; ();
   logic req_valid;
   logic req_ready;
   logic req_write;
   logic req_secure;
   logic [FRAME_W-1:0] req_frame;
   logic [11:0] req_addr;
   logic [31:0] req_wdata;
   logic [3:0] req_strb;
   logic resp_valid;
   logic resp_ready;
   logic resp_err;
   logic [31:0] resp_rdata;
   logic [NUM_LINES-1:0] spi_pulse;
   logic [NUM_LINES-1:0] spi_secure;

   modport frames (
      input req_valid, req_write, req_secure, req_frame, req_addr, req_wdata, req_strb,
      input resp_ready,
      output req_ready, resp_valid, resp_err, resp_rdata, spi_pulse, spi_secure
   );
   modport ctrl (
      output req_valid, req_write, req_secure, req_frame, req_addr, req_wdata, req_strb,
      output resp_ready,
      input req_ready, resp_valid, resp_err, resp_rdata, spi_pulse, spi_secure
   );
endinterface
`default_nettype wire

//--- msi_frame_unit.sv
// Message frame unit: register frames that turn trigger writes into interrupt edges
`timescale 1ns/10ps
`default_nettype none
module msi_frame_unit import msi_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   msi_link_if.frames link,
   output logic msg_accept,
   output logic msg_drop,
   output logic [15:0] drop_count,
   output logic secure_frame_active
);
   // ----------------------------------------------------------------
   // Allocation
   // ----------------------------------------------------------------
   // Secure frame counts only when the controller has security too
   localparam bit SEC_LIVE = SEC_EFF;

   function automatic logic [NUM_LINES-1:0] alloc_mask();
      logic [NUM_LINES-1:0] m;
      m = ns_mask();
      if (SEC_LIVE) begin
         m = m | frame_mask(int'(SEC_FRAME));
      end
      return m;
   endfunction

   function automatic logic [31:0] type_word(input int f);
      return {6'h00, FRAME_BASE[f], 6'h00, FRAME_COUNT[f]};
   endfunction

   localparam logic [NUM_LINES-1:0] ALLOC = alloc_mask();
   localparam logic [NUM_LINES-1:0] SEC_LINES =
      SEC_LIVE ? frame_mask(int'(SEC_FRAME)) : '0;

   // ----------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------
   logic resp_valid_r;
   logic resp_err_r;
   logic [31:0] resp_rdata_r;
   logic resp_err_nxt;
   logic [31:0] resp_rdata_nxt;
   logic [NUM_LINES-1:0] spi_r;
   logic [NUM_LINES-1:0] spi_nxt;
   logic accept_r;
   logic drop_r;
   logic [15:0] drop_cnt_r;

   wire take = link.req_valid & link.req_ready;
   wire frame_exists = int'(link.req_frame) < NUM_FRAMES;
   wire is_sec_frame = link.req_frame == SEC_FRAME;
   // Secure frame invisible to Non-secure accesses, or absent altogether
   wire frame_ok = frame_exists &
      (is_sec_frame ? (SEC_LIVE & link.req_secure) : 1'b1);
   wire sel_type = link.req_addr == OFS_TYPE;
   wire sel_trig = link.req_addr == OFS_TRIGGER;
   wire sel_ident = link.req_addr == OFS_IDENT;
   wire size_ok = (link.req_strb == STRB_WORD) | (link.req_strb == STRB_HALF);
   wire [9:0] trig_id = link.req_wdata[9:0];
   wire id_ok = frame_exists && id_in_frame(int'(link.req_frame), trig_id);
   wire trig_wr = take & link.req_write & frame_ok & sel_trig & size_ok;
   wire trig_hit = trig_wr & id_ok;
   wire trig_miss = trig_wr & ~id_ok;
   wire [9:0] line_id = trig_id - LINE_BASE_ID;
   wire [5:0] line_idx = line_id[5:0];
   wire [31:0] ident_word = {IDENT_PRODUCT, IDENT_ARCH, IDENT_REVISION, IDENT_IMPLEMENTER};

   // ----------------------------------------------------------------
   // Read data and response status
   // ----------------------------------------------------------------
   always_comb begin
      resp_err_nxt = ~frame_ok;
      resp_rdata_nxt = 32'h00000000;
      if (!frame_ok || link.req_write) begin
         resp_rdata_nxt = 32'h00000000;
      end else if (sel_type) begin
         resp_rdata_nxt = type_word(int'(link.req_frame));
      end else if (sel_ident) begin
         resp_rdata_nxt = ident_word;
      end else begin
         resp_rdata_nxt = 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt pulses
   // ----------------------------------------------------------------
   always_comb begin
      spi_nxt = '0;
      if (trig_hit) begin
         spi_nxt[line_idx] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Response channel
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         resp_valid_r <= 1'b0;
      end else if (take) begin
         resp_valid_r <= 1'b1;
      end else if (link.resp_ready) begin
         resp_valid_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         resp_err_r <= 1'b0;
         resp_rdata_r <= 32'h00000000;
      end else if (take) begin
         resp_err_r <= resp_err_nxt;
         resp_rdata_r <= resp_rdata_nxt;
      end
   end

   // Pulses last one cycle; the controller end samples every edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         spi_r <= '0;
      end else begin
         spi_r <= spi_nxt & ALLOC;
      end
   end

   // ----------------------------------------------------------------
   // User-side status
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         accept_r <= 1'b0;
         drop_r <= 1'b0;
      end else begin
         accept_r <= trig_hit;
         drop_r <= trig_miss;
      end
   end

   // Saturates so a storm of bad writes never wraps to a small count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drop_cnt_r <= 16'h0000;
      end else if (trig_miss && drop_cnt_r != 16'hffff) begin
         drop_cnt_r <= drop_cnt_r + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // One request in flight; next one waits for the answer to be taken
   assign link.req_ready = ~resp_valid_r;
   assign link.resp_valid = resp_valid_r;
   assign link.resp_err = resp_err_r;
   assign link.resp_rdata = resp_rdata_r;
   assign link.spi_pulse = spi_r & ALLOC;
   // Without a secure frame every message line reports Non-secure
   assign link.spi_secure = SEC_LINES;
   assign msg_accept = accept_r;
   assign msg_drop = drop_r;
   assign drop_count = drop_cnt_r;
   assign secure_frame_active = SEC_LIVE;
endmodule
`default_nettype wire

//--- msi_to_spi_frame_assertions.sv
// Link checks between the frame unit and the controller end
`timescale 1ns/10ps
`default_nettype none
module msi_to_spi_frame_assertions import msi_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_write,
   input wire logic req_secure,
   input wire logic [FRAME_W-1:0] req_frame,
   input wire logic [11:0] req_addr,
   input wire logic [31:0] req_wdata,
   input wire logic [3:0] req_strb,
   input wire logic resp_valid,
   input wire logic resp_ready,
   input wire logic resp_err,
   input wire logic [31:0] resp_rdata,
   input wire logic [NUM_LINES-1:0] spi_pulse,
   input wire logic [NUM_LINES-1:0] spi_secure
);
   // ----------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------
   wire logic take = req_valid && req_ready;
   wire logic fr_ok = req_frame != 2'h3 && !(req_frame == SEC_FRAME && !req_secure);
   wire logic [9:0] base = FRAME_BASE[req_frame];
   wire logic [9:0] cnt = FRAME_COUNT[req_frame];
   wire logic [9:0] id = req_wdata[9:0];
   wire logic in_rng = id >= base && {1'b0, id} < {1'b0, base} + {1'b0, cnt};
   wire logic strb_ok = req_strb == STRB_WORD || req_strb == STRB_HALF;
   wire logic trig = take && fr_ok && req_write && req_addr == OFS_TRIGGER && strb_ok;
   wire logic hit = trig && in_rng;
   logic [NUM_LINES-1:0] pulse_r;
   logic [31:0] type_r;
   // Captured every edge, so only the take edge matters one cycle on
   always_ff @(posedge aclk) begin
      pulse_r <= 64'h1 << (id - LINE_BASE_ID);
      type_r <= {6'h0, base, 6'h0, cnt};
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_miss;
      trig && !in_rng;
   endsequence
   sequence s_answer;
      resp_valid && !req_ready;
   endsequence
   AST_PULSE_CAUSE: assert property (hit |=> spi_pulse == pulse_r)
      else $error("wrong line pulsed");
   AST_PULSE_SOURCE: assert property (spi_pulse != '0 |-> $past(hit))
      else $error("pulse without trigger");
   AST_PULSE_SINGLE: assert property (spi_pulse != '0
      |=> (spi_pulse & $past(spi_pulse)) == '0) else $error("pulse too long");
   AST_MISS_IGNORED: assert property (s_miss |=> spi_pulse == '0)
      else $error("out of range trigger pulsed");
   AST_SUBSET: assert property ((spi_pulse & ~64'h000000ff0000ffff) == '0)
      else $error("unallocated line pulsed");
   AST_SEC_LINES: assert property (spi_secure == 64'h000000ff00000000)
      else $error("secure line map wrong");
   AST_SEC_REFUSE: assert property (take && req_frame == SEC_FRAME && !req_secure
      |=> s_answer ##0 (resp_err && spi_pulse == '0)) else $error("secure frame not refused");
   AST_TYPE_READ: assert property (take && fr_ok && !req_write && req_addr == OFS_TYPE
      |=> resp_rdata == type_r && !resp_err) else $error("type value wrong");
   AST_ANSWER: assert property (take |=> s_answer)
      else $error("no answer");
endmodule
`default_nettype wire

//--- msi_to_spi_frame_bench.sv
// Self-checking bench: controller end driving the message frame unit
`timescale 1ns/10ps
`default_nettype none
module msi_to_spi_frame_bench import msi_pkg::*; ();
   typedef logic [34:0] note_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b1;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, last_rd;
   note_t exp_q[$];
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [63:0] pend = '0;
   logic [9:0] id;
   logic msg_accept, msg_drop, secure_frame_active, pending_any;
   logic [15:0] drop_count, n_ev = '0;
   msi_link_if link ();
   msi_frame_unit u_msi_frame_unit (.aclk, .aresetn, .link(link.frames), .msg_accept,
      .msg_drop, .drop_count, .secure_frame_active);
   msi_ctrl_end u_msi_ctrl_end (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .link(link.ctrl), .pending_any, .config_error());
   msi_to_spi_frame_assertions u_chk (.aclk, .aresetn, .req_valid(link.req_valid),
      .req_ready(link.req_ready), .req_write(link.req_write), .req_secure(link.req_secure),
      .req_frame(link.req_frame), .req_addr(link.req_addr), .req_wdata(link.req_wdata),
      .req_strb(link.req_strb), .resp_valid(link.resp_valid), .resp_ready(link.resp_ready),
      .resp_err(link.resp_err), .resp_rdata(link.resp_rdata), .spi_pulse(link.spi_pulse),
      .spi_secure(link.spi_secure));
   // ----------------------------------------------------------------
   // Bus tasks; ready and answers are read at the handshake edge
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      exp_q.push_back({1'b1, r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic c, input logic [1:0] r,
                         input logic [31:0] d);
      exp_q.push_back({c, r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      last_rd = s_axi_rdata;
   endtask
   task automatic link_op(input logic [1:0] f, input logic s, input logic w, input logic h,
                          input logic [11:0] ofs, input logic [31:0] d);
      int n;
      axi_wr(C_CTRL, {13'h0, h, w, s, 2'h0, f, ofs}, RESP_OKAY);
      axi_wr(C_DATA, d, RESP_OKAY);
      axi_wr(C_GO, 32'h1, RESP_OKAY);
      n = 0;
      do begin
         axi_rd(C_STATUS, 1'b0, RESP_OKAY, 32'h0);
         n++;
      end while (last_rd[0] === 1'b1 && n < 20);
   endtask
   task automatic check_note(input logic [1:0] resp, input logic [31:0] data);
      note_t n;
      n = exp_q.pop_front();
      if (n[34] === 1'b1) begin
         n_tests++;
         if (resp !== n[33:32] || data !== n[31:0]) begin
            errors++;
            $display("wrong value at %0t: got %h %h want %h", $time, resp, data, n[33:0]);
         end
      end
   endtask
   task automatic tally_and_finish();
      if (errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Clock, watchdog, response monitor
   // ----------------------------------------------------------------
   initial begin
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errors++;
         tally_and_finish();
      end
   end
   always @(negedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) check_note(s_axi_bresp, 32'h0);
      if (s_axi_rvalid && s_axi_rready) check_note(s_axi_rresp, s_axi_rdata);
   end
   always @(posedge aclk) begin
      if (aresetn) n_ev <= n_ev + {7'h0, msg_drop, 7'h0, msg_accept};
   end
   initial begin
      void'($urandom(32'h9964));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axi_wr(C_EDGE_LO, 32'hffffffff, RESP_OKAY);
      axi_wr(C_EDGE_HI, 32'hffffffff, RESP_OKAY);
      axi_wr(8'h40, 32'h1, RESP_SLVERR);
      axi_rd(8'h40, 1'b1, RESP_SLVERR, 32'h0);
      axi_rd(C_STATUS, 1'b1, RESP_OKAY, 32'h4);
      axi_wr(C_GROUP_LO, 32'h0000fffe, RESP_OKAY);
      axi_wr(C_NSAC_LO, 32'h1, RESP_OKAY);
      axi_rd(C_STATUS, 1'b1, RESP_OKAY, 32'h0);
      for (int f = 0; f < NUM_FRAMES; f++) begin
         link_op(2'(f), 1'b1, 1'b0, 1'b0, OFS_TYPE, 32'h0);
         axi_rd(C_DATA, 1'b1, RESP_OKAY, {6'h0, FRAME_BASE[f], 6'h0, FRAME_COUNT[f]});
         for (int k = 0; k < 4; k++) begin
            id = FRAME_BASE[f] + 10'($urandom_range(FRAME_COUNT[f] - 10'h1));
            pend[id - LINE_BASE_ID] = 1'b1;
            link_op(2'(f), 1'b1, 1'b1, 1'($urandom_range(1)), OFS_TRIGGER,
                    ($urandom() & 32'hfffffc00) | {22'h0, id});
         end
         // Edges of the range, one above and one below
         link_op(2'(f), 1'b1, 1'b1, 1'b0, OFS_TRIGGER, {22'h0, FRAME_BASE[f] + FRAME_COUNT[f]});
         link_op(2'(f), 1'b1, 1'b1, 1'b0, OFS_TRIGGER, {22'h0, FRAME_BASE[f] - 10'h1});
         axi_rd(C_PEND_LO, 1'b1, RESP_OKAY, pend[31:0]);
         axi_rd(C_PEND_HI, 1'b1, RESP_OKAY, pend[63:32]);
         axi_wr(C_PEND_LO, pend[31:0], RESP_OKAY);
         axi_wr(C_PEND_HI, pend[63:32], RESP_OKAY);
         pend = '0;
      end
      link_op(2'h1, 1'b0, 1'b0, 1'b0, OFS_IDENT, 32'h0);
      axi_rd(C_DATA, 1'b1, RESP_OKAY,
             {IDENT_PRODUCT, IDENT_ARCH, IDENT_REVISION, IDENT_IMPLEMENTER});
      link_op(SEC_FRAME, 1'b0, 1'b1, 1'b0, OFS_TRIGGER, 32'h40);
      axi_rd(C_STATUS, 1'b1, RESP_OKAY, 32'h2);
      axi_rd(C_PEND_HI, 1'b1, RESP_OKAY, 32'h0);
      link_op(2'h3, 1'b1, 1'b0, 1'b0, OFS_TYPE, 32'h0);
      axi_rd(C_STATUS, 1'b1, RESP_OKAY, 32'h2);
      exp_q.push_back({1'b1, RESP_OKAY, 32'h00020006});
      check_note(RESP_OKAY, {14'h0, secure_frame_active, pending_any, drop_count});
      exp_q.push_back({1'b1, RESP_OKAY, 32'h0000060c});
      check_note(RESP_OKAY, {16'h0, n_ev});
      tally_and_finish();
   end
endmodule
`default_nettype wire
